/* common/iectl_defines.svh */
// offsets, field positions, reset values and counts of the interrupt and event transfer block
// assumes a word-wide register port with an 8-bit word index
`ifndef IECTL_DEFINES_SVH
`define IECTL_DEFINES_SVH

`define IECTL_NODES        8
`define IECTL_CHANS        8
`define IECTL_PERIPH       6
`define IECTL_EXT_NODE     6
`define IECTL_TRAP_BASE    7'h10
`define IECTL_RESP_CYCLES  8

`define IECTL_A_NODE       8'h00
`define IECTL_A_SRC        8'h10
`define IECTL_A_DST        8'h18
`define IECTL_A_CCTL       8'h20
`define IECTL_A_EDGE       8'h28
`define IECTL_A_STAT       8'h29
`define IECTL_A_MASK       8'h2A
`define IECTL_A_CUR        8'h2B

`define IECTL_NC_EN        0
`define IECTL_NC_REQ       1
`define IECTL_NC_PRIO_LSB  2
`define IECTL_NC_ENG       6
`define IECTL_NC_CH_LSB    7

`define IECTL_CC_CNT_LSB   0
`define IECTL_CC_WORD      8
`define IECTL_CC_INCS      9
`define IECTL_CC_INCD      10
`define IECTL_CC_CONT      11

`define IECTL_CUR_REQ      16
`define IECTL_CUR_TRAP     17

`define IECTL_RST_PRIO     4'h0
`define IECTL_RST_CHAN     3'h0
`define IECTL_RST_PTR      24'h000000
`define IECTL_RST_CNT      8'h00
`define IECTL_RST_EDGE     2'h1
`define IECTL_RST_BYTE8    8'h00

`endif

/* common/iectl_pkg.sv */
// types shared by the interrupt and event transfer block
// assumes iectl_defines.svh for all numeric constants
package iectl_pkg;
  typedef logic [3:0]  iectl_prio_t;
  typedef logic [2:0]  iectl_chan_t;
  typedef logic [23:0] iectl_ptr_t;
  typedef logic [7:0]  iectl_cnt_t;
  typedef logic [6:0]  iectl_trap_t;
  typedef logic [15:0] iectl_vec_t;
  typedef enum logic [1:0] {offer_none, offer_node, offer_trap} iectl_offer_t;
endpackage

/* hdl/iectl_top.sv */
// priority interrupt controller with an eight-channel event transfer engine
// assumes the cpu core acknowledges offers, reports its running level and
// performs the memory moves that the transfer strobe announces
`timescale 1ns/1ns
`include "iectl_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - answer requests within eight clocks
// - each node routes to cpu or engine
// - one stolen cycle per transfer
// - byte or word move, optional pointer increments
// - counter decrements unless continuous mode
// - counter zero falls back to vectored interrupt
// - eight channels with own pointers, counter
// - per-node request, enable and priority
// - sixteen priority levels per node
// - only a node of strictly higher priority, or a trap at any level, preempts
// - each node has its own vector
// - external input edge rising, falling, both
// - trap with number vectors by number
// - software setting request raises interrupt
// - vector equals four times trap number
module iectl_top
  import iectl_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [5:0]  periph_req_i,
  input  wire logic        ext_int_i,
  input  wire logic [3:0]  cpu_level_i,
  input  wire logic        int_ack_i,
  input  wire logic        trap_i,
  input  wire logic [6:0]  trap_num_i,
  output logic             int_req_o,
  output logic      [15:0] int_vector_o,
  output logic      [3:0]  int_level_o,
  output logic             int_is_trap_o,
  output logic             xfer_o,
  output logic      [23:0] xfer_src_o,
  output logic      [23:0] xfer_dst_o,
  output logic             xfer_word_o,
  output logic             evt_irq_o
);

  localparam int          NODES  = `IECTL_NODES;
  localparam int          CHANS  = `IECTL_CHANS;
  localparam logic [7:0]  A_NODE = `IECTL_A_NODE;
  localparam logic [7:0]  A_SRC  = `IECTL_A_SRC;
  localparam logic [7:0]  A_DST  = `IECTL_A_DST;
  localparam logic [7:0]  A_CCTL = `IECTL_A_CCTL;
  localparam iectl_trap_t TBASE  = `IECTL_TRAP_BASE;

  //////////////////////////////////////////////////////////////////////////////
  // register port decode

  logic [NODES-1:0] wr_node;
  logic [CHANS-1:0] wr_src;
  logic [CHANS-1:0] wr_dst;
  logic [CHANS-1:0] wr_cctl;
  logic             wr_edge;
  logic             wr_stat;
  logic             wr_mask;

  always_comb begin
    wr_node = '0;
    wr_src  = '0;
    wr_dst  = '0;
    wr_cctl = '0;
    wr_node[addr_i[2:0]] = wr_i && (addr_i[7:3] == A_NODE[7:3]);
    wr_src[addr_i[2:0]]  = wr_i && (addr_i[7:3] == A_SRC[7:3]);
    wr_dst[addr_i[2:0]]  = wr_i && (addr_i[7:3] == A_DST[7:3]);
    wr_cctl[addr_i[2:0]] = wr_i && (addr_i[7:3] == A_CCTL[7:3]);
    wr_edge = wr_i && (addr_i == `IECTL_A_EDGE);
    wr_stat = wr_i && (addr_i == `IECTL_A_STAT);
    wr_mask = wr_i && (addr_i == `IECTL_A_MASK);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state shared between groups

  logic [NODES-1:0] req;
  logic [NODES-1:0] en;
  logic [NODES-1:0] eng;
  iectl_prio_t      prio [NODES];
  iectl_chan_t      chan [NODES];
  iectl_ptr_t       src  [CHANS];
  iectl_ptr_t       dst  [CHANS];
  iectl_cnt_t       cnt  [CHANS];
  logic [CHANS-1:0] word;
  logic [CHANS-1:0] incs;
  logic [CHANS-1:0] incd;
  logic [CHANS-1:0] cont;

  logic [NODES-1:0] hw_set;
  logic [NODES-1:0] hw_clr;
  logic [NODES-1:0] eng_ok;
  logic [NODES-1:0] std_ok;

  iectl_offer_t     off_kind;
  logic [2:0]       off_node;
  logic             trap_pend;
  iectl_trap_t      trap_num;
  logic             ext_prev;
  logic [1:0]       edge_cfg;
  logic [CHANS-1:0] stat;
  logic [CHANS-1:0] mask;

  logic             eng_found;
  logic [2:0]       eng_node;
  logic             std_found;
  logic [2:0]       std_node;
  iectl_chan_t      go_ch;
  logic             go_zero;

  //////////////////////////////////////////////////////////////////////////////
  // external input edge detection

  logic ext_edge;

  always_comb begin
    ext_edge = (ext_int_i && !ext_prev && edge_cfg[0])
            || (!ext_int_i && ext_prev && edge_cfg[1]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-node control: request, enable, priority, routing

  for (genvar n = 0; n < NODES; n++) begin : g_node
    logic        next_req;
    logic        next_en;
    logic        next_eng;
    iectl_prio_t next_prio;
    iectl_chan_t next_chan;

    always_comb begin
      if (n < `IECTL_PERIPH) begin
        // modulo keeps the constant index in range on nodes without a peripheral
        hw_set[n] = periph_req_i[n % `IECTL_PERIPH];
      end else if (n == `IECTL_EXT_NODE) begin
        hw_set[n] = ext_edge;
      end else begin
        hw_set[n] = 1'b0;
      end
      hw_clr[n] = (int_ack_i && off_kind == offer_node && off_node == n)
               || (eng_found && eng_node == n && !go_zero);
      next_en   = en[n];
      next_eng  = eng[n];
      next_prio = prio[n];
      next_chan = chan[n];
      // a software write can set the request on any node, peripheral or not
      if (wr_node[n]) begin
        next_req  = wdata_i[`IECTL_NC_REQ] || hw_set[n];
        next_en   = wdata_i[`IECTL_NC_EN];
        next_prio = wdata_i[`IECTL_NC_PRIO_LSB +: 4];
        next_eng  = wdata_i[`IECTL_NC_ENG];
        next_chan = wdata_i[`IECTL_NC_CH_LSB +: 3];
      end else begin
        // a new event in the clearing cycle is kept
        next_req = hw_set[n] || (req[n] && !hw_clr[n]);
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        req[n]  <= 1'b0;
        en[n]   <= 1'b0;
        eng[n]  <= 1'b0;
        prio[n] <= `IECTL_RST_PRIO;
        chan[n] <= `IECTL_RST_CHAN;
      end else begin
        req[n]  <= next_req;
        en[n]   <= next_en;
        eng[n]  <= next_eng;
        prio[n] <= next_prio;
        chan[n] <= next_chan;
      end
    end

    always_comb begin
      eng_ok[n] = req[n] && en[n] && eng[n]
               && (cont[chan[n]] || cnt[chan[n]] != `IECTL_RST_CNT);
      std_ok[n] = req[n] && en[n] && !eng_ok[n]
               && (prio[n] > cpu_level_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arbitration: highest level wins, lower node index on a tie

  always_comb begin
    iectl_prio_t eb;
    iectl_prio_t sb;
    eb        = '0;
    sb        = '0;
    eng_found = 1'b0;
    eng_node  = '0;
    std_found = 1'b0;
    std_node  = '0;
    for (int n = 0; n < NODES; n++) begin
      if (eng_ok[n] && (!eng_found || prio[n] > eb)) begin
        eng_found = 1'b1;
        eng_node  = n[2:0];
        eb        = prio[n];
      end
      if (std_ok[n] && (!std_found || prio[n] > sb)) begin
        std_found = 1'b1;
        std_node  = n[2:0];
        sb        = prio[n];
      end
    end
    go_ch   = chan[eng_node];
    go_zero = !cont[go_ch] && (cnt[go_ch] == 8'h01);
  end

  //////////////////////////////////////////////////////////////////////////////
  // transfer channels

  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    iectl_ptr_t next_src;
    iectl_ptr_t next_dst;
    iectl_cnt_t next_cnt;
    logic       next_word;
    logic       next_incs;
    logic       next_incd;
    logic       next_cont;
    logic       go;
    iectl_ptr_t step;

    always_comb begin
      go        = eng_found && (go_ch == c);
      step      = word[c] ? 24'h000002 : 24'h000001;
      next_src  = src[c];
      next_dst  = dst[c];
      next_cnt  = cnt[c];
      next_word = word[c];
      next_incs = incs[c];
      next_incd = incd[c];
      next_cont = cont[c];
      if (go) begin
        if (incs[c]) begin
          next_src = src[c] + step;
        end
        if (incd[c]) begin
          next_dst = dst[c] + step;
        end
        if (!cont[c]) begin
          next_cnt = cnt[c] - 8'h01;
        end
      end
      // software reprogramming takes precedence over a service in the same cycle
      if (wr_src[c]) begin
        next_src = wdata_i[23:0];
      end
      if (wr_dst[c]) begin
        next_dst = wdata_i[23:0];
      end
      if (wr_cctl[c]) begin
        next_cnt  = wdata_i[`IECTL_CC_CNT_LSB +: 8];
        next_word = wdata_i[`IECTL_CC_WORD];
        next_incs = wdata_i[`IECTL_CC_INCS];
        next_incd = wdata_i[`IECTL_CC_INCD];
        next_cont = wdata_i[`IECTL_CC_CONT];
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        src[c]  <= `IECTL_RST_PTR;
        dst[c]  <= `IECTL_RST_PTR;
        cnt[c]  <= `IECTL_RST_CNT;
        word[c] <= 1'b0;
        incs[c] <= 1'b0;
        incd[c] <= 1'b0;
        cont[c] <= 1'b0;
      end else begin
        src[c]  <= next_src;
        dst[c]  <= next_dst;
        cnt[c]  <= next_cnt;
        word[c] <= next_word;
        incs[c] <= next_incs;
        incd[c] <= next_incd;
        cont[c] <= next_cont;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transfer strobe: one cycle per service, the program is not redirected

  logic       next_xfer;
  iectl_ptr_t next_xsrc;
  iectl_ptr_t next_xdst;
  logic       next_xword;

  always_comb begin
    next_xfer  = eng_found;
    next_xsrc  = src[go_ch];
    next_xdst  = dst[go_ch];
    next_xword = word[go_ch];
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      xfer_o      <= 1'b0;
      xfer_src_o  <= `IECTL_RST_PTR;
      xfer_dst_o  <= `IECTL_RST_PTR;
      xfer_word_o <= 1'b0;
    end else begin
      xfer_o      <= next_xfer;
      xfer_src_o  <= next_xsrc;
      xfer_dst_o  <= next_xdst;
      xfer_word_o <= next_xword;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vectored offer to the cpu, traps ahead of nodes

  iectl_offer_t next_kind;
  logic [2:0]   next_onode;
  logic         next_trap_pend;
  iectl_trap_t  next_trap_num;
  iectl_vec_t   next_vec;
  iectl_prio_t  next_lvl;
  logic         taken;

  always_comb begin
    taken          = int_ack_i && off_kind != offer_none;
    next_trap_pend = trap_i || (trap_pend && !(taken && off_kind == offer_trap));
    next_trap_num  = trap_i ? trap_num_i : trap_num;
    next_kind      = offer_none;
    next_onode     = off_node;
    next_vec       = int_vector_o;
    next_lvl       = int_level_o;
    // one idle cycle after an acknowledge lets the cleared request settle
    if (!taken) begin
      if (trap_pend) begin
        next_kind = offer_trap;
        next_vec  = {7'h00, trap_num, 2'b00};
        next_lvl  = cpu_level_i;
      end else if (std_found) begin
        next_kind  = offer_node;
        next_onode = std_node;
        next_vec   = {7'h00, TBASE + {4'h0, std_node}, 2'b00};
        next_lvl   = prio[std_node];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      off_kind      <= offer_none;
      off_node      <= 3'h0;
      trap_pend     <= 1'b0;
      trap_num      <= 7'h00;
      int_req_o     <= 1'b0;
      int_vector_o  <= 16'h0000;
      int_level_o   <= `IECTL_RST_PRIO;
      int_is_trap_o <= 1'b0;
    end else begin
      off_kind      <= next_kind;
      off_node      <= next_onode;
      trap_pend     <= next_trap_pend;
      trap_num      <= next_trap_num;
      int_req_o     <= next_kind != offer_none;
      int_vector_o  <= next_vec;
      int_level_o   <= next_lvl;
      int_is_trap_o <= next_kind == offer_trap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel-done status, mask, edge config, event interrupt

  logic [CHANS-1:0] next_stat;
  logic [CHANS-1:0] next_mask;
  logic [1:0]       next_edge;
  logic [CHANS-1:0] done;

  always_comb begin
    done = '0;
    done[go_ch] = eng_found && go_zero;
    next_stat = done | (stat & ~(wr_stat ? wdata_i[CHANS-1:0] : {CHANS{1'b0}}));
    next_mask = wr_mask ? wdata_i[CHANS-1:0] : mask;
    next_edge = wr_edge ? wdata_i[1:0] : edge_cfg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stat      <= `IECTL_RST_BYTE8;
      mask      <= `IECTL_RST_BYTE8;
      edge_cfg  <= `IECTL_RST_EDGE;
      ext_prev  <= 1'b0;
      evt_irq_o <= 1'b0;
    end else begin
      stat      <= next_stat;
      mask      <= next_mask;
      edge_cfg  <= next_edge;
      ext_prev  <= ext_int_i;
      evt_irq_o <= |(next_stat & next_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    if (rd_i) begin
      if (addr_i[7:3] == A_NODE[7:3]) begin
        next_rdata[`IECTL_NC_EN]            = en[addr_i[2:0]];
        next_rdata[`IECTL_NC_REQ]           = req[addr_i[2:0]];
        next_rdata[`IECTL_NC_PRIO_LSB +: 4] = prio[addr_i[2:0]];
        next_rdata[`IECTL_NC_ENG]           = eng[addr_i[2:0]];
        next_rdata[`IECTL_NC_CH_LSB +: 3]   = chan[addr_i[2:0]];
      end else if (addr_i[7:3] == A_SRC[7:3]) begin
        next_rdata[23:0] = src[addr_i[2:0]];
      end else if (addr_i[7:3] == A_DST[7:3]) begin
        next_rdata[23:0] = dst[addr_i[2:0]];
      end else if (addr_i[7:3] == A_CCTL[7:3]) begin
        next_rdata[`IECTL_CC_CNT_LSB +: 8] = cnt[addr_i[2:0]];
        next_rdata[`IECTL_CC_WORD]         = word[addr_i[2:0]];
        next_rdata[`IECTL_CC_INCS]         = incs[addr_i[2:0]];
        next_rdata[`IECTL_CC_INCD]         = incd[addr_i[2:0]];
        next_rdata[`IECTL_CC_CONT]         = cont[addr_i[2:0]];
      end else if (addr_i == `IECTL_A_EDGE) begin
        next_rdata[1:0] = edge_cfg;
      end else if (addr_i == `IECTL_A_STAT) begin
        next_rdata[CHANS-1:0] = stat;
      end else if (addr_i == `IECTL_A_MASK) begin
        next_rdata[CHANS-1:0] = mask;
      end else if (addr_i == `IECTL_A_CUR) begin
        next_rdata[15:0]            = int_vector_o;
        next_rdata[`IECTL_CUR_REQ]  = int_req_o;
        next_rdata[`IECTL_CUR_TRAP] = trap_pend;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // iectl_top

/* verif/iectl_cpu_model.sv */
// cpu core side: accepts vectored offers after a chosen wait
// assumes the offer is a level that stays up until acceptance
`timescale 1ns/1ns
module iectl_cpu_model (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       int_req_i,
  input  wire logic [3:0] lat_i,
  output logic            int_ack_o
);
  logic [3:0] wait_cnt;
  initial int_ack_o = 1'b0;
  // one-cycle acceptance, only while an offer is seen
  always @(posedge clk_sys_i) begin
    if (srst_i || !int_req_i || int_ack_o) begin
      wait_cnt <= 4'h0;
      int_ack_o <= 1'b0;
    end else if (wait_cnt >= lat_i) begin
      int_ack_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // iectl_cpu_model

/* verif/iectl_top_props.sv */
// port-level checks of the interrupt and event transfer block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`include "iectl_defines.svh"
module iectl_top_props (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [5:0]  periph_req_i,
  input wire logic        ext_int_i,
  input wire logic [3:0]  cpu_level_i,
  input wire logic        int_ack_i,
  input wire logic        trap_i,
  input wire logic [6:0]  trap_num_i,
  input wire logic        int_req_o,
  input wire logic [15:0] int_vector_o,
  input wire logic [3:0]  int_level_o,
  input wire logic        int_is_trap_o,
  input wire logic        xfer_o,
  input wire logic [23:0] xfer_src_o,
  input wire logic [23:0] xfer_dst_o,
  input wire logic        xfer_word_o,
  input wire logic        evt_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_ack_drop: assert property (int_req_o && int_ack_i |=> !int_req_o)
    else $error("offer still up after acceptance");
  chk_vec_shape: assert property (int_req_o |-> int_vector_o[1:0] == 2'h0 && int_vector_o[15:9] == 7'h00)
    else $error("vector not four times a trap number");
  chk_level_above: assert property (int_req_o && !int_is_trap_o |-> int_level_o > $past(cpu_level_i))
    else $error("offer not above running level");
  chk_trap_vec: assert property (trap_i && !int_ack_i ##1 !trap_i && !int_ack_i |=> int_req_o && int_is_trap_o && int_vector_o == {7'h00, $past(trap_num_i, 2), 2'h0})
    else $error("trap not offered with its vector");
  chk_trap_resp: assert property (trap_i |-> ##[1:8] int_req_o)
    else $error("no offer within eight clocks");
  chk_evt_cause: assert property ($rose(evt_irq_o) |-> xfer_o || $past(wr_i))
    else $error("event interrupt rose without cause");
  chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  chk_unmapped_rd: assert property (rd_i && addr_i > `IECTL_A_CUR |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // iectl_top_props

bind iectl_top iectl_top_props u_props (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_req_i(periph_req_i),
  .ext_int_i(ext_int_i), .cpu_level_i(cpu_level_i), .int_ack_i(int_ack_i),
  .trap_i(trap_i), .trap_num_i(trap_num_i), .int_req_o(int_req_o),
  .int_vector_o(int_vector_o), .int_level_o(int_level_o), .int_is_trap_o(int_is_trap_o),
  .xfer_o(xfer_o), .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o),
  .xfer_word_o(xfer_word_o), .evt_irq_o(evt_irq_o));

/* verif/interrupt_event_transfer_ctrl_tb.sv */
// self-checking bench: register port, request sources and traps driven here
// assumes the cpu model accepts offers; results checked against queued notes
`timescale 1ns/1ns
`include "iectl_defines.svh"
module interrupt_event_transfer_ctrl_tb;
  logic        clk_sys_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        ext_int_i = 1'b0, trap_i = 1'b0, rd_d = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [5:0]  periph_req_i = 6'h00;
  logic [3:0]  cpu_level_i = 4'h0, int_level_o, lat = 4'h0;
  logic [6:0]  trap_num_i = 7'h00, t;
  logic [1:0]  e;
  logic [23:0] xfer_src_o, xfer_dst_o, s, d;
  logic [15:0] int_vector_o;
  logic        int_ack_i, int_req_o, int_is_trap_o, xfer_o, xfer_word_o, evt_irq_o;
  logic [63:0] vq[$], xq[$], rq[$];
  int          err_total = 0, check_count = 0, cyc = 0, seed = 49, n, k;

  always #20 clk_sys_i = ~clk_sys_i;

  iectl_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_req_i(periph_req_i),
    .ext_int_i(ext_int_i), .cpu_level_i(cpu_level_i), .int_ack_i(int_ack_i),
    .trap_i(trap_i), .trap_num_i(trap_num_i), .int_req_o(int_req_o),
    .int_vector_o(int_vector_o), .int_level_o(int_level_o), .int_is_trap_o(int_is_trap_o),
    .xfer_o(xfer_o), .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o),
    .xfer_word_o(xfer_word_o), .evt_irq_o(evt_irq_o));
  iectl_cpu_model cpu (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .int_req_i(int_req_o),
    .lat_i(lat), .int_ack_o(int_ack_i));

  ////////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic take(ref logic [63:0] q[$], input logic [63:0] got);
    if (q.size() == 0) begin
      err_total++;
      $display("mismatch at %0t: unexpected result %h", $time, got);
    end else cmp(got, q.pop_front());
  endtask
  // results are taken at the edge that samples them, before that edge's updates
  always @(posedge clk_sys_i) begin
    if (!srst_i && int_req_o && int_ack_i) take(vq, {48'h0, int_vector_o});
    if (!srst_i && xfer_o) take(xq, {15'h0, xfer_src_o, xfer_dst_o, xfer_word_o});
    if (rd_d) take(rq, {32'h0, rdata_o});
    rd_d <= rd_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task tick(input int c);
    repeat (c) @(posedge clk_sys_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] v);
    rq.push_back({32'h0, v});
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask
  task nd(input logic [7:0] a, input logic [3:0] p, input logic r, input logic [2:0] c,
          input logic q);
    wr(a, {22'h0, c, r, p, q, 1'b1});
  endtask
  task pulse(input logic [5:0] b);
    @(posedge clk_sys_i);
    periph_req_i <= b;
    @(posedge clk_sys_i);
    periph_req_i <= 6'h00;
  endtask
  // waits for every note to be matched, then idles so strays show up
  task settle;
    for (int i = 0; i < 60 && vq.size() + xq.size() + rq.size() != 0; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    cmp(64'(vq.size() + xq.size() + rq.size()), 64'h0);
    vq.delete();
    xq.delete();
    rq.delete();
    tick(6);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("mismatch at %0t: run timed out", $time);
      summarize;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    srst_i <= 1'b0;
    rd(`IECTL_A_NODE, 32'h0);
    rd(`IECTL_A_EDGE, 32'h1);
    rd(`IECTL_A_STAT, 32'h0);
    rd(8'h3F, 32'h0);
    settle;
    $display("test reset values done");
    for (n = 0; n < 8; n++) begin
      if (n == 6) continue;
      vq.push_back(64'(16'h40 + 4 * n));
      nd(8'(n), 4'(n + 1), 1'b0, 3'h0, 1'(n == 7));
      if (n < 6) pulse(6'(1 << n));
      settle;
      rd(8'(n), {22'h0, 4'h0, 4'(n + 1), 2'h1});
      wr(8'(n), 32'h0);
      settle;
    end
    $display("test node vectors done");
    @(posedge clk_sys_i);
    lat <= 4'($random(seed)) & 4'h7;
    cpu_level_i <= 4'h9;
    nd(8'h02, 4'h3, 1'b0, 3'h0, 1'b0);
    nd(8'h03, 4'hF, 1'b0, 3'h0, 1'b0);
    nd(8'h04, 4'h9, 1'b0, 3'h0, 1'b0);
    vq.push_back(64'h4C);
    pulse(6'h1C);
    settle;
    vq.push_back(64'h50);
    @(posedge clk_sys_i);
    cpu_level_i <= 4'h8;
    settle;
    vq.push_back(64'h48);
    @(posedge clk_sys_i);
    cpu_level_i <= 4'h0;
    settle;
    $display("test priority done");
    lat <= 4'($random(seed)) & 4'h3;
    nd(8'h06, 4'h1, 1'b0, 3'h0, 1'b0);
    for (k = 0; k < 4; k++) begin
      e = 2'(k + 2);
      wr(`IECTL_A_EDGE, {30'h0, e});
      if (e[0]) vq.push_back(64'h58);
      @(posedge clk_sys_i);
      ext_int_i <= 1'b1;
      settle;
      if (e[1]) vq.push_back(64'h58);
      @(posedge clk_sys_i);
      ext_int_i <= 1'b0;
      settle;
    end
    $display("test edge select done");
    for (k = 0; k < 4; k++) begin
      t = 7'($random(seed));
      vq.push_back({48'h0, 7'h00, t, 2'h0});
      @(posedge clk_sys_i);
      trap_i <= 1'b1;
      trap_num_i <= t;
      @(posedge clk_sys_i);
      trap_i <= 1'b0;
      if (k == 3) vq.push_back(64'h5C);
      if (k == 3) nd(8'h07, 4'h2, 1'b0, 3'h0, 1'b1);
      settle;
    end
    $display("test traps done");
    s = 24'($random(seed));
    d = 24'($random(seed));
    wr(8'h12, {8'h00, s});
    wr(8'h1A, {8'h00, d});
    wr(8'h22, 32'h202);
    nd(8'h01, 4'h4, 1'b1, 3'h2, 1'b0);
    xq.push_back({15'h0, s, d, 1'b0});
    pulse(6'h02);
    settle;
    xq.push_back({15'h0, s + 24'h1, d, 1'b0});
    vq.push_back(64'h44);
    pulse(6'h02);
    settle;
    cmp(64'(evt_irq_o), 64'h0);
    wr(`IECTL_A_MASK, 32'hFF);
    #1;
    cmp(64'(evt_irq_o), 64'h1);
    rd(`IECTL_A_STAT, 32'h4);
    rd(8'h22, 32'h200);
    wr(`IECTL_A_STAT, 32'h4);
    rd(`IECTL_A_STAT, 32'h0);
    settle;
    cmp(64'(evt_irq_o), 64'h0);
    wr(8'h15, {8'h00, s});
    wr(8'h1D, {8'h00, d});
    wr(8'h25, 32'hF03);
    nd(8'h00, 4'h7, 1'b1, 3'h5, 1'b0);
    for (k = 0; k < 3; k++) begin
      xq.push_back({15'h0, s + 24'(2 * k), d + 24'(2 * k), 1'b1});
      pulse(6'h01);
      settle;
    end
    rd(8'h25, 32'hF03);
    settle;
    $display("test transfer engine done");
    summarize;
  end
endmodule // interrupt_event_transfer_ctrl_tb
